// [ebrw_bus_seq.sv]
// Purpose: external bus cycle sequencer with ready and programmed waits
// Assumes: clk 25 MHz; clock_output runs at half clk; one request at a time
// Notes:   each state step lasts one clock_output period; wait repeats per wait count, samp while ready is high
`timescale 1ns/1ps
`default_nettype none
module ebrw_bus_seq (
    input  wire logic                     clk,                   // system clock
    input  wire logic                     nrst,                  // async reset, active low
    // register port
    input  wire logic [ebrw_pkg::RAW-1:0] reg_addr,              // register byte address
    input  wire logic [31:0]              reg_wdata,             // register write data
    input  wire logic                     reg_wr,                // write strobe
    input  wire logic                     reg_rd,                // read strobe
    output logic      [31:0]              reg_rdata,             // read data, next cycle
    // user request port
    input  wire logic                     req_valid,             // request present
    input  wire logic                     req_write,             // 1 write, 0 read
    input  wire logic [ebrw_pkg::AW-1:0]  req_addr,              // request address
    input  wire logic [ebrw_pkg::DW-1:0]  req_wdata,             // request write data
    output logic                          req_ready,             // request taken
    output logic                          req_done,              // cycle finished pulse
    output logic      [ebrw_pkg::DW-1:0]  req_rdata,             // captured read data
    // external bus pins
    output logic                          clock_output,          // bus clock out
    output logic                          ale,                   // address latch strobe
    output logic      [ebrw_pkg::AW-1:0]  bus_addr,              // address pins
    output logic                          rd_n,                  // read strobe
    output logic                          wr_n,                  // write strobe
    output logic                          read_chip_select_n,    // read chip select
    output logic                          write_chip_select_n,   // write chip select
    input  wire logic [ebrw_pkg::DW-1:0]  bus_data_in,           // data pins in
    output logic      [ebrw_pkg::DW-1:0]  bus_data_out,          // data pins out
    output logic                          bus_data_oe,           // data pins driven
    input  wire logic                     ready_pin              // ready from partner
);
    typedef struct packed {
        logic [ebrw_pkg::CFG_W-1:0] cfg;     // configuration register
        ebrw_pkg::ebrw_state_t      st;      // bus cycle state
        logic                       co;      // clock_output level
        logic [ebrw_pkg::WCW-1:0]   wcnt;    // memory wait counter
        logic                       wr;      // current cycle is a write
        logic [ebrw_pkg::AW-1:0]    addr;    // address pins
        logic [ebrw_pkg::DW-1:0]    dout;    // data pins out
        logic [ebrw_pkg::DW-1:0]    wdat;    // write data kept for the strobe phase
        logic                       oe;      // data pins driven
        logic                       ale;     // address latch strobe
        logic                       strb;    // command strobe active
        logic [ebrw_pkg::DW-1:0]    rdat;    // captured read data
        logic                       done;    // done pulse
        logic [31:0]                rdo;     // register read data
    } ebrw_seq_t;

    ebrw_seq_t q_r;   // registered state
    ebrw_seq_t q_nxt; // next state

    ebrw_rdy_if rif (); // ready sampler link
    logic       ce;     // clock_output rising edge enable
    logic       take;   // request accepted

    ////////////////////////////////////////////////////////////////
    // ready synchroniser
    ebrw_rdy_sync u_rdy (
        .clk       (clk),
        .nrst      (nrst),
        .ready_pin (ready_pin),
        .rif       (rif.smp)
    );
    assign rif.async_mode = q_r.cfg[ebrw_pkg::CFG_ASYNC];

    // step on each rising edge of clock_output
    assign ce   = !q_r.co;
    assign take = ce && req_valid && (q_r.st == ebrw_pkg::ST_IDLE);
    assign req_ready = take;

    ////////////////////////////////////////////////////////////////
    // cycle outline, one step per clock_output rising edge:
    //   idle - take request, drive address and ale
    //   addr - drop ale, load wait count, strobe now or after delay
    //   dly  - optional delayed strobe assertion
    //   wait - programmed memory wait states, strobe held low
    //   samp - ready high: stay; ready low: capture and end cycle
    //   muxw - turnaround after a multiplexed cycle
    //   triw - optional tristate wait before the next cycle
    // the address returns to zero at the same edge that raises the
    // strobe and takes read data, so late address moves are harmless
    // ready is read only through the synchroniser; its latency is why
    // the partner must hold ready low until the strobe rises
    // next state
    always_comb begin
        q_nxt      = q_r;
        q_nxt.co   = !q_r.co;
        q_nxt.done = 1'b0;
        // register port write and read
        if (reg_wr && reg_addr == ebrw_pkg::REG_CFG) begin
            q_nxt.cfg = reg_wdata[ebrw_pkg::CFG_W-1:0];
        end
        q_nxt.rdo = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                ebrw_pkg::REG_CFG:   q_nxt.rdo = {24'h00_0000, q_r.cfg};
                ebrw_pkg::REG_STAT:  q_nxt.rdo = {27'h000_0000, q_r.st == ebrw_pkg::ST_IDLE,
                                                  q_r.st};
                ebrw_pkg::REG_RDATA: q_nxt.rdo = {16'h0000, q_r.rdat};
                default:             q_nxt.rdo = 32'h0000_0000;
            endcase
        end
        if (ce) begin
            unique case (q_r.st)
                ebrw_pkg::ST_IDLE: begin
                    if (req_valid) begin
                        q_nxt.st   = ebrw_pkg::ST_ADDR;
                        q_nxt.wr   = req_write;
                        q_nxt.addr = req_addr;
                        // request data may drop once taken, keep a copy
                        q_nxt.wdat = req_wdata;
                        q_nxt.ale  = 1'b1;
                        // multiplexed: address travels on data pins too
                        q_nxt.dout = q_r.cfg[ebrw_pkg::CFG_MUX] ? req_addr : req_wdata;
                        q_nxt.oe   = q_r.cfg[ebrw_pkg::CFG_MUX] || req_write;
                    end
                end
                ebrw_pkg::ST_ADDR: begin
                    q_nxt.ale  = 1'b0;
                    q_nxt.wcnt = q_r.cfg[ebrw_pkg::CFG_WC_LSB +: ebrw_pkg::WCW];
                    q_nxt.oe   = q_r.wr;
                    // data pins leave the address: write data, or quiet for reads
                    q_nxt.dout = q_r.wr ? q_r.wdat : '0;
                    if (q_r.cfg[ebrw_pkg::CFG_DLY]) begin
                        q_nxt.st = ebrw_pkg::ST_DLY;
                    end else begin
                        q_nxt.strb = 1'b1;
                        q_nxt.st   = (q_nxt.wcnt != '0) ? ebrw_pkg::ST_WAIT
                                                        : ebrw_pkg::ST_SAMP;
                    end
                end
                ebrw_pkg::ST_DLY: begin
                    q_nxt.strb = 1'b1;
                    q_nxt.st   = (q_r.wcnt != '0) ? ebrw_pkg::ST_WAIT : ebrw_pkg::ST_SAMP;
                end
                ebrw_pkg::ST_WAIT: begin
                    q_nxt.wcnt = q_r.wcnt - 1'b1;
                    if (q_r.wcnt == 'd1) begin
                        q_nxt.st = ebrw_pkg::ST_SAMP;
                    end
                end
                ebrw_pkg::ST_SAMP: begin
                    if (!rif.ready_lvl) begin
                        if (!q_r.wr) begin
                            q_nxt.rdat = bus_data_in;
                        end
                        q_nxt.strb = 1'b0;
                        q_nxt.done = 1'b1;
                        q_nxt.oe   = 1'b0;
                        q_nxt.addr = '0;
                        if (q_r.cfg[ebrw_pkg::CFG_MUX]) begin
                            q_nxt.st = ebrw_pkg::ST_MUXW;
                        end else if (q_r.cfg[ebrw_pkg::CFG_TRI]) begin
                            q_nxt.st = ebrw_pkg::ST_TRIW;
                        end else begin
                            q_nxt.st = ebrw_pkg::ST_IDLE;
                        end
                    end
                end
                ebrw_pkg::ST_MUXW: begin
                    q_nxt.st = q_r.cfg[ebrw_pkg::CFG_TRI] ? ebrw_pkg::ST_TRIW
                                                          : ebrw_pkg::ST_IDLE;
                end
                ebrw_pkg::ST_TRIW: begin
                    q_nxt.st = ebrw_pkg::ST_IDLE;
                end
                default: q_nxt.st = ebrw_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register
    // reset leaves the bus idle, config at its reset value and
    // clock_output low, so the first step follows the first edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_r      <= '0;
            q_r.cfg  <= ebrw_pkg::CFG_RST;
            q_r.st   <= ebrw_pkg::ST_IDLE;
        end else begin
            q_r <= q_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs: every pin comes from a state flop or from a decode of
    // the strobe and direction flops, which never change together
    // inside a cycle, so the strobes cannot glitch
    // chip selects follow the strobes one to one
    assign reg_rdata           = q_r.rdo;
    assign req_done            = q_r.done;
    assign req_rdata           = q_r.rdat;
    assign clock_output        = q_r.co;
    assign ale                 = q_r.ale;
    assign bus_addr            = q_r.addr;
    assign rd_n                = !(q_r.strb && !q_r.wr);
    assign wr_n                = !(q_r.strb && q_r.wr);
    assign read_chip_select_n  = rd_n;
    assign write_chip_select_n = wr_n;
    assign bus_data_out        = q_r.dout;
    assign bus_data_oe         = q_r.oe;
endmodule // ebrw_bus_seq
`default_nettype wire

// [ebrw_mem_model.sv]
// Purpose: external memory answering sequencer cycles
// Assumes: extra sets ready-high time in clk pairs from ale
// Notes:   idle data pins show inverted contents
`timescale 1ns/1ps
`default_nettype none
module ebrw_mem_model (
    input  wire logic        clk,          // system clock
    input  wire logic        nrst,         // async reset, active low
    input  wire logic        ale,          // address latch strobe
    input  wire logic        rd_n,         // read strobe
    input  wire logic        wr_n,         // write strobe
    input  wire logic        mux,          // address rides data pins
    input  wire logic [3:0]  extra,        // wait request length
    input  wire logic [15:0] bus_addr,     // address pins
    input  wire logic [15:0] bus_data_out, // data from sequencer
    output logic      [15:0] bus_data_in,  // data to sequencer
    output logic             ready_pin     // high = wait
);
    logic [15:0] mem [16];  // small storage
    logic [3:0]  a_r;       // latched address
    logic [7:0]  cnt_r;     // clk count since ale
    logic        s_r;       // strobes idle last cycle
    logic        end_r;     // strobe rose, ready released
    // latch address, count, store write data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            a_r <= 4'h0;
            cnt_r <= 8'h00;
            s_r <= 1'h1;
            end_r <= 1'h1;
        end else begin
            s_r <= rd_n & wr_n;
            if (ale) begin
                a_r <= mux ? bus_data_out[3:0] : bus_addr[3:0];
                cnt_r <= 8'h00;
                end_r <= 1'h0;
            end else if (cnt_r != 8'hFF) cnt_r <= cnt_r + 8'h01;
            if (!s_r && rd_n && wr_n) end_r <= 1'h1;
            if (!wr_n) mem[a_r] <= bus_data_out;
        end
    end
    assign ready_pin = end_r || (cnt_r < {3'h0, extra, 1'h0});
    assign bus_data_in = rd_n ? ~mem[a_r] : mem[a_r];
endmodule // ebrw_mem_model
`default_nettype wire

// [ebrw_pkg.sv]
// Purpose: shared constants and types for the external bus cycle sequencer
// Assumes: one 25 MHz clock, word-wide register port
// Notes:   register map, field positions and bus cycle states
package ebrw_pkg;
    localparam int AW = 16;                        // external address width
    localparam int DW = 16;                        // external data width
    localparam int RAW = 8;                        // register port address width
    localparam int WCW = 4;                        // wait-state counter width
    // register byte addresses
    localparam logic [7:0] REG_CFG   = 8'h00;      // configuration
    localparam logic [7:0] REG_STAT  = 8'h04;      // status
    localparam logic [7:0] REG_RDATA = 8'h08;      // last captured read data
    // configuration fields
    localparam int CFG_WC_LSB = 0;                 // memory_cycle_wait_count lsb
    localparam int CFG_DLY    = 4;                 // strobe delay enable
    localparam int CFG_MUX    = 5;                 // multiplexed bus mode
    localparam int CFG_TRI    = 6;                 // tristate_turnaround_wait enable
    localparam int CFG_ASYNC  = 7;                 // asynchronous ready mode
    localparam int CFG_W      = 8;                 // configuration width
    localparam logic [CFG_W-1:0] CFG_RST = 8'h00;  // configuration reset value
    // bus cycle states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_DLY, ST_WAIT, ST_SAMP, ST_MUXW, ST_TRIW
    } ebrw_state_t;
endpackage

// [ebrw_rdy_if.sv]
// Purpose: carries ready sampling signals between sequencer and sampler
// Assumes: both ends on clk
// Notes:   pin itself stays a top-level port
`timescale 1ns/1ps
`default_nettype none
interface ebrw_rdy_if;
    logic async_mode;   // ready mode select
    logic ready_lvl;    // synchronised ready level
    modport seq (output async_mode, input ready_lvl);
    modport smp (input async_mode, output ready_lvl);
endinterface // ebrw_rdy_if
`default_nettype wire

// [ebrw_rdy_sync.sv]
// Purpose: brings the ready pin into the clk domain
// Assumes: ready pin is asynchronous to clk
// Notes:   async mode adds two further stages of settling
`timescale 1ns/1ps
`default_nettype none
module ebrw_rdy_sync (
    input  wire logic clk,        // system clock
    input  wire logic nrst,       // async reset, active low
    input  wire logic ready_pin,  // ready pin from outside
    ebrw_rdy_if.smp   rif         // towards the sequencer
);
    typedef struct packed {
        logic s1;   // first stage, read only by s2
        logic s2;   // second stage
        logic s3;   // async extra stage
        logic s4;   // async extra stage
    } ebrw_sync_t;

    ebrw_sync_t q_r;   // registered stages
    ebrw_sync_t q_nxt; // next stages

    ////////////////////////////////////////////////////////////////
    // next value of the chain
    always_comb begin
        q_nxt    = q_r;
        q_nxt.s1 = ready_pin;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;
        q_nxt.s4 = q_r.s3;
    end

    // stages reset high: treat bus as not ready until seen low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= '1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign rif.ready_lvl = rif.async_mode ? q_r.s4 : q_r.s2;
endmodule // ebrw_rdy_sync
`default_nettype wire

// [ebrw_seq_asserts.sv]
// Purpose: pin-level checks of the external bus cycle sequencer
// Assumes: single clk domain, nrst asynchronous active low
// Notes:   bound to every ebrw_bus_seq instance
`timescale 1ns/1ps
`default_nettype none
module ebrw_seq_asserts (
    input wire logic        clk,                 // system clock
    input wire logic        nrst,                // async reset, active low
    input wire logic        ale,                 // address latch strobe
    input wire logic        rd_n,                // read strobe
    input wire logic        wr_n,                // write strobe
    input wire logic        read_chip_select_n,  // read chip select
    input wire logic        write_chip_select_n, // write chip select
    input wire logic        clock_output,        // bus clock out
    input wire logic        ready_pin,           // ready from partner
    input wire logic        req_done,            // cycle finished pulse
    input wire logic [15:0] req_rdata,           // captured read data
    input wire logic [15:0] bus_data_in,         // data pins in
    input wire logic        bus_data_oe          // data pins driven
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    chk_ready_wait: assert property ((!rd_n && ready_pin) [*8] |=> !rd_n)
        else $error("read strobe ended while ready held high");
    chk_end_done: assert property (($rose(rd_n) || $rose(wr_n)) |-> req_done)
        else $error("strobe rose without done pulse");
    chk_rd_capture: assert property ($rose(rd_n) |-> req_rdata == $past(bus_data_in))
        else $error("read data not taken at strobe rise");
    chk_strobe_place: assert property (
        ($fell(rd_n) || $fell(wr_n)) |-> $past(ale) || $past(ale, 3))
        else $error("strobe fell at wrong distance from ale");
    chk_done_pulse: assert property (req_done |=> !req_done)
        else $error("done pulse longer than one cycle");
    // the edge that releases reset still resets the divider, so skip it
    chk_clk_toggle: assert property ($past(nrst) |=> clock_output != $past(clock_output))
        else $error("bus clock out missed a toggle");
    chk_cs_mirror: assert property (read_chip_select_n == rd_n && write_chip_select_n == wr_n)
        else $error("chip select differs from strobe");
    chk_ale_apart: assert property (ale |-> rd_n && wr_n)
        else $error("strobe low during address latch");
    chk_oe_dir: assert property ((!wr_n |-> bus_data_oe) and (!rd_n |-> !bus_data_oe))
        else $error("data pin drive does not match strobe direction");
endmodule // ebrw_seq_asserts
bind ebrw_bus_seq ebrw_seq_asserts u_ebrw_seq_asserts (.clk, .nrst, .ale, .rd_n, .wr_n,
    .read_chip_select_n, .write_chip_select_n, .clock_output, .ready_pin, .req_done,
    .req_rdata, .bus_data_in, .bus_data_oe);
`default_nettype wire

// [external_bus_ready_wait_control_tb_top.sv]
// Purpose: register and bus cycle sequences with expected values
// Assumes: clk 40 ns, strobe timings counted in clk cycles
// Notes:   gaps are compared against the plain demux case
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
module external_bus_ready_wait_control_tb_top;
    logic        clk, nrst, reg_wr, reg_rd, req_valid, req_write, req_ready, req_done;
    logic        clock_output, ale, rd_n, wr_n, rcs_n, wcs_n, bus_data_oe, ready_pin, mux;
    logic [7:0]  reg_addr, c;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] req_addr, req_wdata, req_rdata, bus_addr, bus_data_in, bus_data_out, d;
    logic [3:0]  ext;
    logic [7:0]  cfg_t [7] = '{8'h00, 8'h03, 8'h10, 8'h20, 8'h60, 8'h40, 8'h80};
    logic [3:0]  ext_t [7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4};
    int          n_errors, checks, cyc, t_af, t_ar, t_sr, ts, g, base;
    ebrw_bus_seq u_ebrw_bus_seq (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready, .req_done,
        .req_rdata, .clock_output, .ale, .bus_addr, .rd_n, .wr_n, .read_chip_select_n(rcs_n),
        .write_chip_select_n(wcs_n), .bus_data_in, .bus_data_out, .bus_data_oe, .ready_pin);
    ebrw_mem_model u_ebrw_mem_model (.clk, .nrst, .ale, .rd_n, .wr_n, .mux, .extra(ext),
        .bus_addr, .bus_data_out, .bus_data_in, .ready_pin);
    ////////////////////////////////////////////////////////////////////////////////
    // clock and edge-time monitor: edges are stamped in their own time
    // step, before any task wakes at the following negative edge
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk) cyc++;
    always @(posedge ale) t_ar = cyc;
    always @(negedge ale) t_af = cyc;
    always @(posedge rd_n or posedge wr_n) t_sr = cyc;
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) begin
            reg_addr <= a;
            reg_wdata <= v;
            reg_wr <= 1'h1;
        end
        @(posedge clk) reg_wr <= 1'h0;
    endtask
    task automatic reg_rd_t(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk) begin
            reg_addr <= a;
            reg_rd <= 1'h1;
        end
        @(posedge clk) reg_rd <= 1'h0;
        @(negedge clk) `CHK(reg_rdata, e)
    endtask
    // one bus cycle: hold request until taken, wait for done
    task automatic bus_op(input logic w, input logic [15:0] a, input logic [15:0] v);
        int n;
        @(posedge clk) begin
            req_valid <= 1'h1;
            req_write <= w;
            req_addr <= a;
            req_wdata <= v;
        end
        n = 0;
        do @(negedge clk) n++; while (req_ready !== 1'h1 && n < 400);
        @(posedge clk) req_valid <= 1'h0;
        do @(negedge clk) n++; while (req_done !== 1'h1 && n < 400);
        if (n >= 400) begin
            n_errors++;
            report_and_stop();
        end
    endtask
    initial begin
        {nrst, reg_wr, reg_rd, req_valid, req_write, mux} = 6'h00;
        {reg_addr, reg_wdata, req_addr, req_wdata, ext} = 76'h0;
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        reg_rd_t(ebrw_pkg::REG_CFG, 32'h0);
        reg_rd_t(ebrw_pkg::REG_STAT, 32'h10);
        reg_rd_t(8'h0C, 32'h0);
        for (int i = 0; i < 7; i++) begin
            c = cfg_t[i];
            ext <= ext_t[i];
            mux <= c[5];
            reg_wr_t(ebrw_pkg::REG_CFG, {24'h0, c});
            reg_rd_t(ebrw_pkg::REG_CFG, {24'h0, c});
            d = 16'hA5C0 ^ 16'(i);
            bus_op(1'h1, 16'(i), d);
            ts = t_sr;
            bus_op(1'h0, 16'(i), 16'h0);
            g = t_ar - ts;
            if (i == 0) base = g;
            `CHK(req_rdata, d)
            reg_rd_t(ebrw_pkg::REG_RDATA, {16'h0, d});
            `CHK(g - base, 2 * (int'(c[5]) + int'(c[6])))
            if (ext_t[i] == 4'h0 && !c[7])
                `CHK(t_sr - t_af, 2 * (1 + c[4] + c[3:0]))
            else `CHK(t_sr - t_af > 2 * (1 + c[4] + c[3:0]), 1'b1)
            $display("test cfg %h done", c);
        end
        report_and_stop();
    end
endmodule // external_bus_ready_wait_control_tb_top
`undef CHK
`default_nettype wire
